// ===== design/ifv_pkg.sv
// Constants, field layout and carrier types of the flag and vector block
package ifv_pkg;

  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 16;
  localparam int NUM_SRC = 15;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] FLAGS_IDX  = 4'h0;
  localparam logic [ADDR_W-1:0] VECTOR_IDX = 4'h1;

  // Flag bit positions in the flag register
  localparam int RX0_BIT   = 0;
  localparam int TX0_BIT   = 1;
  localparam int START_BIT = 2;
  localparam int STOP_BIT  = 3;
  localparam int ARB_BIT   = 4;
  localparam int NACK_BIT  = 5;
  localparam int BCNT_BIT  = 6;
  localparam int CLTO_BIT  = 7;
  localparam int RX1_BIT   = 8;
  localparam int TX1_BIT   = 9;
  localparam int RX2_BIT   = 10;
  localparam int TX2_BIT   = 11;
  localparam int RX3_BIT   = 12;
  localparam int TX3_BIT   = 13;
  localparam int BIT9_BIT  = 14;

  // Reset value: all transmit-empty flags start set
  localparam logic [DATA_W-1:0] FLAGS_RESET = 16'h2A02;
  // Bit 15 is reserved and reads zero
  localparam logic [DATA_W-1:0] FLAGS_MASK  = 16'h7FFF;
  localparam logic [DATA_W-1:0] ZERO_WORD   = 16'h0000;
  localparam logic [DATA_W-1:0] ONE_WORD    = 16'h0001;
  localparam logic [DATA_W-1:0] CODE_MASK   = 16'h001E;
  localparam logic [3:0]        SRC_NONE    = 4'h0;
  localparam logic [3:0]        SRC_ONE     = 4'h1;

  typedef logic [3:0] ifv_bit_idx_t;

  // Flag bit served at each priority rank, highest first
  localparam ifv_bit_idx_t PRIO_ORDER [NUM_SRC] = '{
    4'h4, 4'h5, 4'h2, 4'h3, 4'hC, 4'hD, 4'hA, 4'hB,
    4'h8, 4'h9, 4'h0, 4'h1, 4'h6, 4'h7, 4'hE
  };

  // Event strobes from the serial engine, one cycle each
  typedef struct packed {
    logic       clock_low_timeout;
    logic       byte_count_zero;
    logic       no_ack;
    logic       arbitration_lost;
    logic       stop_seen;
    logic       start_seen;
    logic [3:0] tx_empty;
    logic [3:0] rx_full;
    logic       ninth_bit;
  } ifv_events_t;

  // Operating mode and per-address match of the current frame
  typedef struct packed {
    logic       master;
    logic [3:0] addr_seen;
  } ifv_mode_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ifv_bus_req_t;

  // Rank (1 = highest) of the first pending source, zero when none
  function automatic logic [3:0] ifv_top_src(input logic [DATA_W-1:0] flags);
    logic [3:0] rank;
    rank = SRC_NONE;
    for (int p = NUM_SRC - 1; p >= 0; p--) begin
      if (flags[PRIO_ORDER[p]]) begin
        rank = 4'(p + 1);
      end
    end
    return rank;
  endfunction : ifv_top_src

endpackage : ifv_pkg

// ===== design/ifv_vec_enc.sv
// Priority encoder turning pending flags into a vector code and a clear mask
`timescale 1ns/1ns
`default_nettype none
module ifv_vec_enc
  import ifv_pkg::*;
(
  input  wire logic [DATA_W-1:0] i_flags,
  output logic      [DATA_W-1:0] o_code,
  output logic      [DATA_W-1:0] o_clr_one
);

  logic [3:0] top_rank;
  logic       any_pending;

  // Rank doubled gives an even code, zero when idle
  assign top_rank    = ifv_top_src(i_flags);
  assign any_pending = (top_rank != SRC_NONE);
  assign o_code      = {11'h000, top_rank, 1'b0};
  assign o_clr_one   = any_pending ?
                       (ONE_WORD << PRIO_ORDER[top_rank - SRC_ONE]) : ZERO_WORD;

endmodule : ifv_vec_enc
`default_nettype wire

// ===== design/ifv_flags_vector.sv
// Interrupt flag register and prioritised vector register of the serial unit
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Each flag bit reads 1 while its source is pending and 0 otherwise.
// - The no-acknowledge flag is set by hardware only in master operation.
// - Transmit-empty for address 0 sets in master operation or in a matched slave frame.
// - Receive-full for address 0 sets in master operation or in a matched slave frame.
// - In slave operation the address-0 flags set only if own address 0 was seen this frame.
// - The vector reads an even code for the top pending source, zero when idle.
// - Any write to the vector clears all pending flags regardless of data.
// - Codes run 02h arbitration lost up to 1Eh ninth bit in the fixed order.
// - Arbitration lost has top priority and ninth bit the lowest.
module ifv_flags_vector
  import ifv_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_srst,
  input  wire ifv_bus_req_t      i_bus,
  input  wire ifv_events_t       i_events,
  input  wire ifv_mode_t         i_mode,
  output logic      [DATA_W-1:0] o_rdata,
  output logic      [DATA_W-1:0] o_flags
);

  // Assertions below all sample on the rising clock and pause in reset
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic              sel_flags;
  logic              sel_vector;
  logic              flags_wr;
  logic              vector_wr;
  logic              vector_rd;
  logic              flags_rd;

  // Address decode and strobe qualification
  assign sel_flags  = (i_bus.addr == FLAGS_IDX);
  assign sel_vector = (i_bus.addr == VECTOR_IDX);
  assign flags_wr   = i_bus.wr & sel_flags;
  assign vector_wr  = i_bus.wr & sel_vector;
  assign flags_rd   = i_bus.rd & sel_flags;
  assign vector_rd  = i_bus.rd & sel_vector;

  ////////////////////////////////////////////////////////////////////////////
  // Hardware set conditions

  logic              is_master;
  logic              is_slave;
  logic [3:0]        addr_ok;
  logic [DATA_W-1:0] hw_set;

  assign is_master = i_mode.master;
  assign is_slave  = ~i_mode.master;

  // Address 0 flags also serve master operation, slave ones need a match
  assign addr_ok[0] = is_master | i_mode.addr_seen[0];
  assign addr_ok[1] = is_slave & i_mode.addr_seen[1];
  assign addr_ok[2] = is_slave & i_mode.addr_seen[2];
  assign addr_ok[3] = is_slave & i_mode.addr_seen[3];

  // Set vector, one bit per flag position
  assign hw_set[RX0_BIT]   = i_events.rx_full[0] & addr_ok[0];
  assign hw_set[TX0_BIT]   = i_events.tx_empty[0] & addr_ok[0];
  assign hw_set[START_BIT] = i_events.start_seen;
  assign hw_set[STOP_BIT]  = i_events.stop_seen;
  assign hw_set[ARB_BIT]   = i_events.arbitration_lost & is_master;
  assign hw_set[NACK_BIT]  = i_events.no_ack & is_master;
  assign hw_set[BCNT_BIT]  = i_events.byte_count_zero;
  assign hw_set[CLTO_BIT]  = i_events.clock_low_timeout;
  assign hw_set[RX1_BIT]   = i_events.rx_full[1] & addr_ok[1];
  assign hw_set[TX1_BIT]   = i_events.tx_empty[1] & addr_ok[1];
  assign hw_set[RX2_BIT]   = i_events.rx_full[2] & addr_ok[2];
  assign hw_set[TX2_BIT]   = i_events.tx_empty[2] & addr_ok[2];
  assign hw_set[RX3_BIT]   = i_events.rx_full[3] & addr_ok[3];
  assign hw_set[TX3_BIT]   = i_events.tx_empty[3] & addr_ok[3];
  assign hw_set[BIT9_BIT]  = i_events.ninth_bit;
  assign hw_set[DATA_W-1]  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Vector encoding

  logic [DATA_W-1:0] vec_code;
  logic [DATA_W-1:0] vec_clr_one;

  // Top pending source and the one-hot mask of its flag
  ifv_vec_enc u_vec_enc (
    .i_flags   (o_flags),
    .o_code    (vec_code),
    .o_clr_one (vec_clr_one)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flag register next value

  logic [DATA_W-1:0] flags_base;
  logic [DATA_W-1:0] next_flags;
  logic [DATA_W-1:0] next_rdata;

  // Software effect first, then hardware sets win over any clear
  assign flags_base = flags_wr  ? (i_bus.wdata & FLAGS_MASK) :
                      vector_wr ? ZERO_WORD :
                      vector_rd ? (o_flags & ~vec_clr_one) :
                      o_flags;
  assign next_flags = (flags_base | hw_set) & FLAGS_MASK;

  // Read data mux, unmapped addresses read zero
  assign next_rdata = flags_rd  ? o_flags :
                      vector_rd ? (vec_code & CODE_MASK) :
                      ZERO_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Flag storage
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_flags <= FLAGS_RESET;
    end else begin
      o_flags <= next_flags;
    end
  end

  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata <= ZERO_WORD;
    end else begin
      o_rdata <= i_bus.rd ? next_rdata : ZERO_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic quiet_sw;
  logic no_events;

  // Helper terms for the properties below
  assign quiet_sw  = ~i_bus.wr & ~i_bus.rd;
  assign no_events = (i_events == '0);

  property p_start_sets;
    i_events.start_seen |=> o_flags[START_BIT];
  endproperty
  a_start_sets : assert property (p_start_sets)
    else $error("start event did not set its flag");

  property p_nack_slave_hold;
    is_slave && quiet_sw |=> o_flags[NACK_BIT] == $past(o_flags[NACK_BIT]);
  endproperty
  a_nack_slave_hold : assert property (p_nack_slave_hold)
    else $error("no-ack flag changed in slave operation");

  property p_arb_master;
    is_master && i_events.arbitration_lost |=> o_flags[ARB_BIT]
      ##0 (vec_code == 16'h0002);
  endproperty
  a_arb_master : assert property (p_arb_master)
    else $error("arbitration loss not flagged at top priority");

  property p_tx0_master;
    is_master && i_events.tx_empty[0] |=> o_flags[TX0_BIT];
  endproperty
  a_tx0_master : assert property (p_tx0_master)
    else $error("address 0 transmit flag not set in master operation");

  property p_rx0_master;
    is_master && i_events.rx_full[0] |=> o_flags[RX0_BIT];
  endproperty
  a_rx0_master : assert property (p_rx0_master)
    else $error("address 0 receive flag not set in master operation");

  property p_rx0_unmatched;
    is_slave && !i_mode.addr_seen[0] && quiet_sw && !o_flags[RX0_BIT]
      |=> !o_flags[RX0_BIT];
  endproperty
  a_rx0_unmatched : assert property (p_rx0_unmatched)
    else $error("address 0 receive flag set without address match");

  property p_vec_even_idle;
    (vec_code[0] == 1'b0) && ((o_flags == ZERO_WORD) == (vec_code == ZERO_WORD));
  endproperty
  a_vec_even_idle : assert property (p_vec_even_idle)
    else $error("vector code odd or not zero when idle");

  property p_wr_clears_all;
    vector_wr && no_events |=> o_flags == ZERO_WORD;
  endproperty
  a_wr_clears_all : assert property (p_wr_clears_all)
    else $error("vector write left a flag pending");

  property p_ninth_code;
    (o_flags == (ONE_WORD << BIT9_BIT)) |-> vec_code == 16'h001E;
  endproperty
  a_ninth_code : assert property (p_ninth_code)
    else $error("ninth bit source has wrong code");

  property p_nack_over_start;
    !o_flags[ARB_BIT] && o_flags[NACK_BIT] && o_flags[START_BIT]
      |-> vec_code == 16'h0004;
  endproperty
  a_nack_over_start : assert property (p_nack_over_start)
    else $error("priority order broken between no-ack and start");

  property p_read_clears_one;
    vector_rd && no_events && (vec_code != ZERO_WORD)
      |=> (o_rdata == $past(vec_code))
      && (o_flags == ($past(o_flags) & ~$past(vec_clr_one)));
  endproperty
  a_read_clears_one : assert property (p_read_clears_one)
    else $error("vector read returned wrong code or cleared wrong flags");

  property p_rdata_one_cycle;
    !$past(i_bus.rd) |-> o_rdata == ZERO_WORD;
  endproperty
  a_rdata_one_cycle : assert property (p_rdata_one_cycle)
    else $error("read data present outside the answer cycle");

  property p_stop_sets;
    i_events.stop_seen |=> o_flags[STOP_BIT];
  endproperty
  a_stop_sets : assert property (p_stop_sets)
    else $error("stop event did not set its flag");

  property p_reserved_zero;
    o_flags[DATA_W-1] == 1'b0;
  endproperty
  a_reserved_zero : assert property (p_reserved_zero)
    else $error("reserved flag bit reads one");

  property p_flags_write;
    flags_wr && no_events |=> o_flags == ($past(i_bus.wdata) & FLAGS_MASK);
  endproperty
  a_flags_write : assert property (p_flags_write)
    else $error("flag register write not taken");

  property p_flags_read_clean;
    flags_rd && no_events |=> (o_flags == $past(o_flags)) && (o_rdata == $past(o_flags));
  endproperty
  a_flags_read_clean : assert property (p_flags_read_clean)
    else $error("flag register read wrong or not free of side effects");

  property p_nack_master_sets;
    is_master && i_events.no_ack |=> o_flags[NACK_BIT];
  endproperty
  a_nack_master_sets : assert property (p_nack_master_sets)
    else $error("no-ack event lost in master operation");

  property p_arb_slave_ignored;
    is_slave && i_events.arbitration_lost && quiet_sw && !o_flags[ARB_BIT] |=> !o_flags[ARB_BIT];
  endproperty
  a_arb_slave_ignored : assert property (p_arb_slave_ignored)
    else $error("arbitration loss flagged in slave operation");

  property p_tx0_slave_match;
    is_slave && i_mode.addr_seen[0] && i_events.tx_empty[0] |=> o_flags[TX0_BIT];
  endproperty
  a_tx0_slave_match : assert property (p_tx0_slave_match)
    else $error("address 0 transmit flag not set in matched slave frame");

  property p_rx0_slave_match;
    is_slave && i_mode.addr_seen[0] && i_events.rx_full[0] |=> o_flags[RX0_BIT];
  endproperty
  a_rx0_slave_match : assert property (p_rx0_slave_match)
    else $error("address 0 receive flag not set in matched slave frame");

  property p_tx0_unmatched;
    is_slave && !i_mode.addr_seen[0] && quiet_sw && !o_flags[TX0_BIT] |=> !o_flags[TX0_BIT];
  endproperty
  a_tx0_unmatched : assert property (p_tx0_unmatched)
    else $error("address 0 transmit flag set without address match");

  property p_stop_code;
    !o_flags[ARB_BIT] && !o_flags[NACK_BIT] && !o_flags[START_BIT] && o_flags[STOP_BIT]
      |-> vec_code == 16'h0008;
  endproperty
  a_stop_code : assert property (p_stop_code)
    else $error("stop source has wrong code");

  property p_rx0_code;
    (o_flags == (ONE_WORD << RX0_BIT)) |-> vec_code == 16'h0016;
  endproperty
  a_rx0_code : assert property (p_rx0_code)
    else $error("address 0 receive source has wrong code");

  property p_bcnt_code;
    (o_flags == (ONE_WORD << BCNT_BIT)) |-> vec_code == 16'h001A;
  endproperty
  a_bcnt_code : assert property (p_bcnt_code)
    else $error("byte counter source has wrong code");

  property p_clto_code;
    (o_flags == (ONE_WORD << CLTO_BIT)) |-> vec_code == 16'h001C;
  endproperty
  a_clto_code : assert property (p_clto_code)
    else $error("clock-low timeout source has wrong code");

  property p_rdata_code_only;
    $past(vector_rd) |-> (o_rdata & ~CODE_MASK) == ZERO_WORD;
  endproperty
  a_rdata_code_only : assert property (p_rdata_code_only)
    else $error("vector read returned bits outside the code field");

  // Main scenarios
  c_read_vector : cover property (vector_rd && vec_code != ZERO_WORD);
  c_write_vector : cover property (vector_wr && o_flags != ZERO_WORD);
  c_set_on_clear : cover property (vector_wr && !no_events);
  c_slave_match : cover property (is_slave && i_mode.addr_seen[2] &&
                                  i_events.rx_full[2]);

endmodule : ifv_flags_vector
`default_nettype wire

// ===== testbench/ifv_engine_model.sv
// Behavioural serial engine that turns a flag-position mask into event strobes
`timescale 1ns/1ns
`default_nettype none
module ifv_engine_model
  import ifv_pkg::*;
(
  input  wire logic [DATA_W-1:0] i_mask,
  output var  ifv_events_t       o_events
);
  // Each flag position raises the strobe of its own source for as long as the mask holds it
  assign o_events = '{clock_low_timeout: i_mask[CLTO_BIT], byte_count_zero: i_mask[BCNT_BIT],
    no_ack: i_mask[NACK_BIT], arbitration_lost: i_mask[ARB_BIT], stop_seen: i_mask[STOP_BIT],
    start_seen: i_mask[START_BIT],
    tx_empty: {i_mask[TX3_BIT], i_mask[TX2_BIT], i_mask[TX1_BIT], i_mask[TX0_BIT]},
    rx_full: {i_mask[RX3_BIT], i_mask[RX2_BIT], i_mask[RX1_BIT], i_mask[RX0_BIT]},
    ninth_bit: i_mask[BIT9_BIT]};
endmodule : ifv_engine_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the flag and vector block against a behavioural model
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import ifv_pkg::*;
;
  logic         i_ref_clk;
  logic         i_srst;
  ifv_bus_req_t bus;
  ifv_mode_t    mode;
  logic [15:0]  mask;
  ifv_events_t  ev;
  logic [15:0]  o_rdata;
  logic [15:0]  o_flags;
  logic [15:0]  exp_flags;
  logic [15:0]  exp_rdata;
  logic [15:0]  nf;
  logic         chk_on;
  int           rank;
  int           n_errors;
  int           checks_done;
  int           seed;
  // Flag positions from highest to lowest priority
  int prio [15] = '{ARB_BIT, NACK_BIT, START_BIT, STOP_BIT, RX3_BIT, TX3_BIT, RX2_BIT, TX2_BIT,
                    RX1_BIT, TX1_BIT, RX0_BIT, TX0_BIT, BCNT_BIT, CLTO_BIT, BIT9_BIT};

  ifv_flags_vector ifv_flags_vector_inst (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_bus(bus),
    .i_events(ev), .i_mode(mode), .o_rdata(o_rdata), .o_flags(o_flags));
  ifv_engine_model ifv_engine_model_inst (.i_mask(mask), .o_events(ev));

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Rank of the first pending source, zero when idle
  function automatic int top_rank(input logic [15:0] f);
    for (int p = 0; p < 15; p++) begin
      if (f[prio[p]]) begin
        return p + 1;
      end
    end
    return 0;
  endfunction : top_rank

  // Strobes that the current mode lets through
  function automatic logic [15:0] gate(input logic [15:0] m, input ifv_mode_t md);
    logic [15:0] g;
    g = m & 16'h7FFF;
    g[NACK_BIT] &= md.master;
    g[ARB_BIT] &= md.master;
    g[RX0_BIT] &= md.master | md.addr_seen[0];
    g[TX0_BIT] &= md.master | md.addr_seen[0];
    for (int i = 1; i < 4; i++) begin
      g[6 + 2 * i] &= !md.master & md.addr_seen[i];
      g[7 + 2 * i] &= !md.master & md.addr_seen[i];
    end
    return g;
  endfunction : gate

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  // One bus cycle launched just after a rising edge
  task automatic bus_op(input logic wr, input logic rd, input logic [3:0] a,
                        input logic [15:0] d);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: d, wr: wr, rd: rd};
  endtask : bus_op

  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  //////////////////////////////////////////////////////////////////////////////////////////////
  always #50 i_ref_clk = ~i_ref_clk;

  // Reference model: reads see pre-edge flags, sets beat clears
  always @(posedge i_ref_clk) begin
    rank = top_rank(exp_flags);
    exp_rdata <= 16'h0000;
    if (i_srst) begin
      exp_flags <= 16'h2A02;
    end else begin
      nf = exp_flags;
      if (bus.rd && bus.addr == 4'h1) begin
        exp_rdata <= 16'(2 * rank);
        if (rank > 0) nf[prio[rank - 1]] = 1'b0;
      end
      if (bus.rd && bus.addr == 4'h0) exp_rdata <= exp_flags;
      if (bus.wr && bus.addr == 4'h1) nf = 16'h0000;
      if (bus.wr && bus.addr == 4'h0) nf = bus.wdata & 16'h7FFF;
      exp_flags <= nf | gate(mask, mode);
    end
  end

  // Every settled cycle is compared
  always @(negedge i_ref_clk) begin
    if (chk_on) begin
      cmp_word(o_flags, exp_flags);
      cmp_word(o_rdata, exp_rdata);
    end
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(100 * 6000);
    n_errors++;
    report_and_stop();
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 1'b0;
    i_srst = 1'b1;
    bus = '0;
    mode = '0;
    mask = 16'h0000;
    chk_on = 1'b0;
    n_errors = 0;
    checks_done = 0;
    seed = 96881;
    repeat (8) @(posedge i_ref_clk);
    chk_on <= 1'b1;
    i_srst <= 1'b0;
    mode <= '{master: 1'b1, addr_seen: 4'h0};
    // Single-source codes, then a full drain in priority order
    for (int b = 0; b < 15; b++) begin
      bus_op(1'b1, 1'b0, 4'h0, 16'(1 << b));
      bus_op(1'b0, 1'b1, 4'h1, 16'h0000);
    end
    bus_op(1'b1, 1'b0, 4'h0, 16'hFFFF);
    for (int p = 0; p < 15; p++) begin
      bus_op(1'b0, 1'b1, 4'h1, 16'h0000);
      bus_op(1'b0, 1'b0, 4'h0, 16'h0000);
      @(negedge i_ref_clk);
      cmp_word(o_rdata, 16'(2 * p + 2));
    end
    // Any write to the vector empties the flags
    bus_op(1'b1, 1'b0, 4'h0, 16'h7FFF);
    bus_op(1'b1, 1'b0, 4'h1, 16'h5A3C);
    bus_op(1'b0, 1'b0, 4'h0, 16'h0000);
    @(negedge i_ref_clk);
    cmp_word(o_flags, 16'h0000);
    // Byte-counter event serviced at once by a vector read
    @(posedge i_ref_clk);
    mask <= 16'(1 << BCNT_BIT);
    @(posedge i_ref_clk);
    mask <= 16'h0000;
    bus_op(1'b0, 1'b1, 4'h1, 16'h0000);
    bus_op(1'b0, 1'b0, 4'h0, 16'h0000);
    @(negedge i_ref_clk);
    cmp_word(o_rdata, 16'h001A);
    // Random traffic with a reset in mid-run
    for (int k = 0; k < 1500; k++) begin
      @(posedge i_ref_clk);
      mask <= 16'($random(seed) & $random(seed) & $random(seed));
      mode <= ifv_mode_t'(5'($random(seed)));
      case (3'($random(seed)))
        3'h0: bus <= '{addr: 4'($random(seed) & 32'h3), wdata: 16'($random(seed)),
                       wr: 1'b1, rd: 1'b0};
        3'h1, 3'h2, 3'h3: bus <= '{addr: 4'($random(seed) & 32'h3), wdata: 16'h0000,
                                   wr: 1'b0, rd: 1'b1};
        default: bus <= '0;
      endcase
      i_srst <= (k >= 700 && k < 702);
    end
    @(posedge i_ref_clk);
    bus <= '0;
    repeat (2) @(posedge i_ref_clk);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
